// file: acs_sequencer.sv
`timescale 1ns/1ps

module acs_sequencer
   import acs_pkg::*;
#(
   parameter int ADDR_W     = 10,    // Acquisition memory address width
   parameter int RECORD_LEN = 1024   // Writes in one burst record
)
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic              phase_clk,
   input  wire logic              trig_gate,
   input  wire logic              two_mhz_data_clock,
   input  wire logic              trig_location,
   output logic                   sample_clk_en,
   output logic                   trig_arm,
   output logic                   pretrig_flush,
   output logic                   readout_shift,
   output logic                   mem_owner,
   output logic                   save_write_clock,
   output logic      [ADDR_W-1:0] mem_addr,
   output logic      [ADDR_W-1:0] record_end,
   output logic                   acq_done,
   output logic                   roll_point
);

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   acs_setup_t   setup;          // Setup registers
   acs_state_t   state;          // Sequencer state
   acs_state_t   next_state;     // Sequencer state, next value
   acs_mode_t    mode;           // Mode latched at start
   acs_mode_t    next_mode;      // Mode, next value
   acs_pins_t    sync1;          // First synchroniser stage
   acs_pins_t    sync2;          // Second synchroniser stage
   acs_pins_t    sync3;          // Delay stage for edge detection
   acs_pins_t    rise;           // Rising edges of pin inputs
   logic         bus_req;        // New bus request this cycle
   logic         bus_wr;         // Write taking effect at the ack edge
   logic         start_pulse;    // Start strobe from software
   logic         stop_pulse;     // Stop strobe from software
   logic [15:0]  sample_cnt;     // Phase clock count in a phase
   logic [15:0]  wr_cnt;         // Writes in a burst save
   logic [1:0]   pass_cnt;       // Writes passed for this point
   logic [32:0]  block_acc;      // Blocked time in ns
   logic         wr;             // Memory write this cycle
   logic         done_evt;       // Record complete this cycle

   // ----------------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------------

   // Byte-lane merge of a write
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

   // States in which sampling clocks run
   function automatic logic is_sampling(input acs_state_t s);
      return (s == ST_PRE) || (s == ST_WAIT) || (s == ST_POST) || (s == ST_ROLL);
   endfunction

   // ----------------------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------------------
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // Writes land where the master samples ack, never earlier
   assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

   // Ack one cycle after the request, dropped the next
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= bus_req;
      end
   end

   // Read data, zero for unmapped offsets
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wb_dat_o <= 32'h0;
      end
      else if (bus_req && !wb_we_i)
      begin
         unique case (wb_adr_i)
            ACS_CTRL_OFS: wb_dat_o <= {29'h0, setup.roll, 2'h0};
            ACS_TPD_OFS:  wb_dat_o <= setup.tpd;
            ACS_PRE_OFS:  wb_dat_o <= {16'h0, setup.pre};
            ACS_POST_OFS: wb_dat_o <= {16'h0, setup.post};
            ACS_STAT_OFS: wb_dat_o <= {22'h0, mode, 1'b0, state};
            ACS_REND_OFS: wb_dat_o <= {{(32-ADDR_W){1'b0}}, record_end};
            ACS_ADDR_OFS: wb_dat_o <= {{(32-ADDR_W){1'b0}}, mem_addr};
            default:      wb_dat_o <= 32'h0;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Setup registers and strobes
   // ----------------------------------------------------------------------------

   // Setup written by the host before start
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         setup.tpd  <= TPD_RST;
         setup.pre  <= PRE_RST;
         setup.post <= POST_RST;
         setup.roll <= 1'b0;
      end
      else if (bus_wr)
      begin
         unique case (wb_adr_i)
            ACS_CTRL_OFS:
            begin
               if (wb_sel_i[0])
               begin
                  setup.roll <= wb_dat_i[CTRL_ROLL_BIT];
               end
            end
            ACS_TPD_OFS:  setup.tpd  <= lane_merge(setup.tpd, wb_dat_i, wb_sel_i);
            ACS_PRE_OFS:  setup.pre  <= 16'(lane_merge({16'h0, setup.pre}, wb_dat_i, wb_sel_i));
            ACS_POST_OFS: setup.post <= 16'(lane_merge({16'h0, setup.post}, wb_dat_i, wb_sel_i));
            default:
            begin
               // Other offsets ignore writes
            end
         endcase
      end
   end

   // Start and stop strobes, one cycle each
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         start_pulse <= 1'b0;
         stop_pulse  <= 1'b0;
      end
      else
      begin
         start_pulse <= bus_wr & wb_sel_i[0] & (wb_adr_i == ACS_CTRL_OFS)
                        & wb_dat_i[CTRL_START_BIT];
         stop_pulse  <= bus_wr & wb_sel_i[0] & (wb_adr_i == ACS_CTRL_OFS)
                        & wb_dat_i[CTRL_STOP_BIT];
      end
   end

   // ----------------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------------

   // Two stages, then a third for edges
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end
      else
      begin
         sync1 <= {trig_location, two_mhz_data_clock, trig_gate, phase_clk};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign rise = sync2 & ~sync3;

   // ----------------------------------------------------------------------------
   // Sequencer state machine
   // ----------------------------------------------------------------------------

   // Next state and mode
   always_comb
   begin
      next_state = state;
      next_mode  = mode;
      done_evt   = 1'b0;
      unique case (state)
         ST_IDLE:
         begin
            if (start_pulse)
            begin
               if (setup.roll)
               begin
                  next_mode  = MODE_ROLL;
                  next_state = ST_ROLL;
               end
               else
               begin
                  next_mode  = (setup.tpd <= TPD_LIMIT_NS) ? MODE_BURST : MODE_SHORT;
                  next_state = ST_PRE;
               end
            end
         end
         ST_PRE:
         begin
            if (sample_cnt >= setup.pre)
            begin
               next_state = ST_WAIT;
            end
         end
         ST_WAIT:
         begin
            if (rise.trig)
            begin
               next_state = ST_POST;
            end
         end
         ST_POST:
         begin
            if (sample_cnt >= setup.post)
            begin
               if (mode == MODE_BURST)
               begin
                  next_state = ST_READ;
               end
               else
               begin
                  next_state = ST_IDLE;
                  done_evt   = 1'b1;
               end
            end
         end
         ST_READ:
         begin
            if (rise.tloc)
            begin
               next_state = ST_SAVE;
            end
         end
         ST_SAVE:
         begin
            if (wr_cnt == 16'(RECORD_LEN))
            begin
               next_state = ST_IDLE;
               done_evt   = 1'b1;
            end
         end
         ST_ROLL:
         begin
            next_state = ST_ROLL;
         end
      endcase
      if (stop_pulse && state != ST_IDLE)
      begin
         next_state = ST_IDLE;
         done_evt   = 1'b0;
      end
   end

   // State and mode registers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= ST_IDLE;
         mode  <= MODE_BURST;
      end
      else
      begin
         state <= next_state;
         mode  <= next_mode;
      end
   end

   // Phase clock count, restarted in each phase
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sample_cnt <= 16'h0;
      end
      else if (next_state != state)
      begin
         sample_cnt <= 16'h0;
      end
      else if (rise.phase && sample_cnt != 16'hffff)
      begin
         sample_cnt <= sample_cnt + 16'h1;
      end
   end

   // Control outputs follow the next state
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sample_clk_en <= 1'b0;
         trig_arm      <= 1'b0;
         pretrig_flush <= 1'b0;
         readout_shift <= 1'b0;
         mem_owner     <= 1'b0;
         acq_done      <= 1'b0;
      end
      else
      begin
         sample_clk_en <= is_sampling(next_state);
         trig_arm      <= (next_state == ST_WAIT);
         pretrig_flush <= (next_state == ST_WAIT) && (next_mode == MODE_BURST);
         readout_shift <= (next_state == ST_READ) || (next_state == ST_SAVE);
         mem_owner     <= (next_state == ST_SAVE) || (next_state == ST_ROLL)
                          || (is_sampling(next_state) && next_mode == MODE_SHORT);
         acq_done      <= done_evt;
      end
   end

   // ----------------------------------------------------------------------------
   // Save write clock gating
   // ----------------------------------------------------------------------------

   // Pass all data clocks in burst, two per point otherwise
   assign wr = rise.dclk & mem_owner
               & ((mode == MODE_BURST) | (pass_cnt != PASS_PER_PT));

   // Pass count and blocked-time accumulator
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pass_cnt  <= 2'h0;
         block_acc <= 33'h0;
      end
      else if (!mem_owner || mode == MODE_BURST)
      begin
         pass_cnt  <= 2'h0;
         block_acc <= 33'h0;
      end
      else if (rise.dclk)
      begin
         if (pass_cnt != PASS_PER_PT)
         begin
            pass_cnt <= pass_cnt + 2'h1;
         end
         else if (block_acc + {1'b0, TPD_LIMIT_NS} >= {1'b0, setup.tpd})
         begin
            pass_cnt  <= 2'h0;
            block_acc <= 33'h0;
         end
         else
         begin
            block_acc <= block_acc + {1'b0, TPD_LIMIT_NS};
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Memory address, record end and strobes
   // ----------------------------------------------------------------------------

   // Address counter wraps, so memory is circular
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mem_addr         <= '0;
         record_end       <= '0;
         save_write_clock <= 1'b0;
         roll_point       <= 1'b0;
      end
      else
      begin
         save_write_clock <= wr;
         roll_point       <= wr & (mode == MODE_ROLL) & (pass_cnt == 2'h1);
         if (wr)
         begin
            mem_addr   <= mem_addr + 1'b1;
            record_end <= mem_addr;
         end
      end
   end

   // Writes in the burst save
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_cnt <= 16'h0;
      end
      else if (state != ST_SAVE)
      begin
         wr_cnt <= 16'h0;
      end
      else if (wr)
      begin
         wr_cnt <= wr_cnt + 16'h1;
      end
   end

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   burst_mode_sel_a: assert property (
      state == ST_IDLE && start_pulse && !setup.roll && setup.tpd <= TPD_LIMIT_NS
      |=> mode == MODE_BURST && state == ST_PRE)
      else $error("burst mode not selected");

   short_mode_sel_a: assert property (
      state == ST_IDLE && start_pulse && !setup.roll && setup.tpd > TPD_LIMIT_NS
      |=> mode == MODE_SHORT ##1 mem_owner)
      else $error("short pipeline not selected");

   sample_until_trig_a: assert property (
      (state == ST_PRE || state == ST_WAIT) |-> sample_clk_en)
      else $error("sampling stopped before trigger");

   arm_after_pre_a: assert property (
      $rose(trig_arm) |-> state == ST_WAIT && $past(state) == ST_PRE)
      else $error("trigger armed early");

   burst_halt_a: assert property (
      state == ST_POST && mode == MODE_BURST && next_state == ST_READ
      |=> !sample_clk_en && readout_shift)
      else $error("sampling not halted");

   addr_step_a: assert property (
      wr |=> mem_addr == $past(mem_addr) + 1'b1 ##0 save_write_clock)
      else $error("address not incremented");

   rec_end_latch_a: assert property (
      wr |=> record_end == $past(mem_addr))
      else $error("record end not latched");

   done_handover_a: assert property (
      acq_done |-> !mem_owner && state == ST_IDLE ##1 !acq_done)
      else $error("completion without hand over");

   roll_no_trig_a: assert property (
      mode == MODE_ROLL |-> !trig_arm)
      else $error("trigger armed in rolling mode");

   two_pass_a: assert property (
      mode == MODE_SHORT && pass_cnt == PASS_PER_PT && rise.dclk |-> !wr)
      else $error("write passed while blocked");

   burst_run_c:  cover property (state == ST_SAVE ##1 acq_done);
   short_run_c:  cover property (mode == MODE_SHORT && state == ST_POST ##1 acq_done);
   roll_run_c:   cover property (mode == MODE_ROLL && roll_point);
   wrap_addr_c:  cover property (wr && mem_addr == '1);

endmodule

// file: acs_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types of the acquisition sequencer
// ----------------------------------------------------------------------------
package acs_pkg;

   // ----------------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------------
   localparam logic [7:0] ACS_CTRL_OFS   = 8'h00;  // Start, stop, rolling select
   localparam logic [7:0] ACS_TPD_OFS    = 8'h04;  // Time per division in ns
   localparam logic [7:0] ACS_PRE_OFS    = 8'h08;  // Pretrigger sample count
   localparam logic [7:0] ACS_POST_OFS   = 8'h0c;  // Post-trigger sample count
   localparam logic [7:0] ACS_STAT_OFS   = 8'h10;  // State and mode, read only
   localparam logic [7:0] ACS_REND_OFS   = 8'h14;  // Record-end latch, read only
   localparam logic [7:0] ACS_ADDR_OFS   = 8'h18;  // Address counter, read only

   // ----------------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------------
   localparam int CTRL_START_BIT = 0;              // Write 1 starts an acquisition
   localparam int CTRL_STOP_BIT  = 1;              // Write 1 aborts, ends rolling
   localparam int CTRL_ROLL_BIT  = 2;              // Rolling display select
   localparam int STAT_MODE_LSB  = 8;              // Mode field in status

   // ----------------------------------------------------------------------------
   // Values after reset and timing figures
   // ----------------------------------------------------------------------------
   localparam logic [31:0] TPD_RST      = 32'h0000c350;  // 50 us
   localparam logic [15:0] PRE_RST      = 16'h0200;      // Half a record
   localparam logic [15:0] POST_RST     = 16'h0200;      // Half a record
   localparam logic [31:0] TPD_LIMIT_NS = 32'h0000c350;  // 50 us burst limit
   localparam logic [1:0]  PASS_PER_PT  = 2'h2;          // Write pulses per point

   // ----------------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------------
   typedef enum logic [6:0]
   {
      ST_IDLE = 7'h01,
      ST_PRE  = 7'h02,
      ST_WAIT = 7'h04,
      ST_POST = 7'h08,
      ST_READ = 7'h10,
      ST_SAVE = 7'h20,
      ST_ROLL = 7'h40
   } acs_state_t;

   typedef enum logic [1:0]
   {
      MODE_BURST = 2'h0,
      MODE_SHORT = 2'h1,
      MODE_ROLL  = 2'h2
   } acs_mode_t;

   // Setup written by software
   typedef struct packed
   {
      logic [31:0] tpd;
      logic [15:0] pre;
      logic [15:0] post;
      logic        roll;
   } acs_setup_t;

   // Synchronised pin inputs, one bit each
   typedef struct packed
   {
      logic tloc;
      logic dclk;
      logic trig;
      logic phase;
   } acs_pins_t;

endpackage

// file: acs_far_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Far side: phase clock array, trigger logic and data clock source
// ----------------------------------------------------------------------------
module acs_far_model
(
   input  wire logic clk,
   output logic      phase_clk,
   output logic      trig_gate,
   output logic      two_mhz_data_clock,
   output logic      trig_location
);
   logic [3:0] pins = 4'h0;  // Bit 0 phase, 1 gate, 2 data clock, 3 location

   assign {trig_location, two_mhz_data_clock, trig_gate, phase_clk} = pins;

   // Pulses held three cycles each way so the two-stage sync sees them
   task automatic pulse(input int b, input int n);
      repeat (n)
      begin
         @(posedge clk);
         pins[b] <= 1'b1;
         repeat (3) @(posedge clk);
         pins[b] <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
endmodule

// file: tb_top.sv
`timescale 1ns/1ps

module tb_top;
   import acs_pkg::*;
   logic        clk = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0]  wb_adr_i = '0;
   logic [3:0]  wb_sel_i = '0;
   logic [31:0] wb_dat_i = '0, wb_dat_o, rnd = 32'h55a73ec7;
   logic        wb_ack_o, phase_clk, trig_gate, two_mhz_data_clock, trig_location;
   logic        sample_clk_en, trig_arm, pretrig_flush, readout_shift, mem_owner;
   logic        save_write_clock, acq_done, roll_point;
   logic [2:0]  mem_addr, record_end;
   int          err_count = 0, num_checks = 0, wr_cnt = 0, done_cnt = 0, pt_cnt = 0, w0, p0;
   logic [31:0] expq[$];  // Expected read data, oldest first

   // Small memory and record keep the run short
   acs_sequencer #(.ADDR_W(3), .RECORD_LEN(8)) dut_u (.clk, .rst_b, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .phase_clk, .trig_gate,
      .two_mhz_data_clock, .trig_location, .sample_clk_en, .trig_arm, .pretrig_flush,
      .readout_shift, .mem_owner, .save_write_clock, .mem_addr, .record_end, .acq_done, .roll_point);
   acs_far_model far_u (.clk, .phase_clk, .trig_gate, .two_mhz_data_clock, .trig_location);

   initial forever #20 clk = ~clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      @(posedge clk);
      while (wb_ack_o !== 1'b1) @(posedge clk);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      expq.push_back(exp);
      wb(1'b0, a, 32'h0);
   endtask

   // Monitor: read data against the oldest note, pulse counting
   always @(posedge clk)
   begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
         chk(wb_dat_o, expq.pop_front());
      if (save_write_clock === 1'b1) wr_cnt++;
      if (acq_done === 1'b1) done_cnt++;
      if (roll_point === 1'b1) pt_cnt++;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      close_out();
   end

   // ----------------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      rd(ACS_TPD_OFS, TPD_RST);
      rd(ACS_PRE_OFS, {16'h0, PRE_RST});
      rd(ACS_STAT_OFS, 32'h1);
      rd(8'h1c, 32'h0);
      rnd = lfsr(rnd);
      wb(1'b1, ACS_TPD_OFS, rnd);
      rd(ACS_TPD_OFS, rnd);
      $display("test registers done");
      // Burst at the 50 us boundary
      wb(1'b1, ACS_TPD_OFS, TPD_LIMIT_NS);
      wb(1'b1, ACS_PRE_OFS, 32'h2);
      wb(1'b1, ACS_POST_OFS, 32'h2);
      wb(1'b1, ACS_CTRL_OFS, 32'h1);
      rd(ACS_STAT_OFS, 32'h2);
      chk(sample_clk_en, 32'h1);
      far_u.pulse(0, 2);
      chk({trig_arm, pretrig_flush}, 32'h3);
      rd(ACS_STAT_OFS, 32'h4);
      far_u.pulse(1, 1);
      rd(ACS_STAT_OFS, 32'h8);
      far_u.pulse(0, 2);
      chk({sample_clk_en, readout_shift}, 32'h1);
      rd(ACS_STAT_OFS, 32'h10);
      far_u.pulse(3, 1);
      chk(mem_owner, 32'h1);
      w0 = wr_cnt;
      far_u.pulse(2, 8);
      chk(wr_cnt - w0, 32'h8);
      chk({done_cnt[30:0], mem_owner}, 32'h2);
      rd(ACS_ADDR_OFS, 32'h0);
      rd(ACS_REND_OFS, 32'h7);
      $display("test burst done");
      // Short pipeline, two blocked edges per point
      wb(1'b1, ACS_TPD_OFS, 32'h000186a0);
      wb(1'b1, ACS_CTRL_OFS, 32'h1);
      rd(ACS_STAT_OFS, 32'h102);
      w0 = wr_cnt;
      far_u.pulse(2, 8);
      chk(wr_cnt - w0, 32'h4);
      chk({mem_owner, pretrig_flush}, 32'h2);
      far_u.pulse(0, 2);
      far_u.pulse(1, 1);
      far_u.pulse(0, 2);
      chk({done_cnt[30:0], mem_owner}, 32'h4);
      $display("test short done");
      // Rolling display
      wb(1'b1, ACS_CTRL_OFS, 32'h5);
      rd(ACS_STAT_OFS, 32'h240);
      w0 = wr_cnt;
      p0 = pt_cnt;
      far_u.pulse(2, 8);
      chk(trig_arm, 32'h0);
      chk(pt_cnt - p0, 32'h2);
      chk(wr_cnt - w0, 32'h4);
      wb(1'b1, ACS_CTRL_OFS, 32'h2);
      // Idle again, mode field keeps the rolling mode latched at start
      rd(ACS_STAT_OFS, 32'h201);
      $display("test roll done");
      // Reset in mid-run
      wb(1'b1, ACS_CTRL_OFS, 32'h0);
      wb(1'b1, ACS_CTRL_OFS, 32'h1);
      // Short pipeline running before reset hits it
      rd(ACS_STAT_OFS, 32'h102);
      rst_b <= 1'b0;
      @(posedge clk);
      chk({sample_clk_en, trig_arm, mem_owner}, 32'h0);
      rst_b <= 1'b1;
      rd(ACS_STAT_OFS, 32'h1);
      $display("test reset done");
      close_out();
   end
endmodule
